// ==== sga_host_model.sv ====
// ============================================================================
// Host side of the command port: writes commands, parameters and memory bytes.
module sga_host_model (
  input wire logic clk, // System clock.
  output logic cmd_wr, // Command byte strobe.
  output logic param_wr, // Parameter or data byte strobe.
  output logic [7:0] bus_data // Byte driven to the device.
);
  timeunit 1ns;
  timeprecision 1ps;

  // The bus idles at a value that differs from the last byte, so nothing can lean on stale data.
  initial begin
    cmd_wr = 1'b0;
    param_wr = 1'b0;
    bus_data = 8'h00;
  end

  // One command byte, launched on a falling edge and held across one rising edge.
  task automatic put_cmd(input logic [7:0] b);
    @(negedge clk);
    cmd_wr = 1'b1;
    bus_data = b;
    @(negedge clk);
    cmd_wr = 1'b0;
    bus_data = ~b;
  endtask : put_cmd

  // One parameter or memory byte; a command must already have opened the sequence.
  task automatic put_param(input logic [7:0] b);
    @(negedge clk);
    param_wr = 1'b1;
    bus_data = b;
    @(negedge clk);
    param_wr = 1'b0;
    bus_data = ~b;
  endtask : put_param

  // Glyph load preamble: table base, rightward step, cursor, then memory write.
  task automatic glyph_load_open(input logic [15:0] base, input logic [15:0] curs);
    put_cmd(8'h5C);
    put_param(base[7:0]);
    put_param(base[15:8]);
    put_cmd(8'h4C);
    put_cmd(8'h46);
    put_param(curs[7:0]);
    put_param(curs[15:8]);
    put_cmd(8'h42);
  endtask : glyph_load_open
endmodule : sga_host_model

// ==== sga_pkg.sv ====
package sga_pkg;
  // ==========================================================================
  // Register indices inside the controller register file.
  localparam logic [4:0] MODE_OFS = 5'h00;
  localparam logic [4:0] VIS_BYTES_OFS = 5'h03;
  localparam logic [4:0] PITCH_LO_OFS = 5'h06;
  localparam logic [4:0] PITCH_HI_OFS = 5'h07;
  localparam logic [4:0] BLK1_LO_OFS = 5'h0B;
  localparam logic [4:0] BLK1_HI_OFS = 5'h0C;
  localparam logic [4:0] BLK2_LO_OFS = 5'h0E;
  localparam logic [4:0] BLK2_HI_OFS = 5'h0F;
  localparam logic [4:0] DIR_OFS = 5'h17;
  localparam logic [4:0] GBASE_LO_OFS = 5'h19;
  localparam logic [4:0] GBASE_HI_OFS = 5'h1A;
  localparam logic [4:0] PIX_SCROLL_OFS = 5'h1B;
  localparam logic [4:0] CURSOR_LO_OFS = 5'h1C;
  localparam logic [4:0] CURSOR_HI_OFS = 5'h1D;
  localparam logic [7:0] REG_RESET = 8'h00;
  // ==========================================================================
  // Field positions.
  localparam int MODE_EXT_CG_BIT = 0;
  localparam int MODE_TALL_BIT = 2;
  localparam int PIX_SCROLL_MSB = 2;
  // ==========================================================================
  // Command codes and their parameter counts.
  localparam logic [7:0] CMD_SYSTEM_SET = 8'h40;
  localparam logic [7:0] CMD_SCROLL = 8'h44;
  localparam logic [7:0] CMD_PIX_SCROLL = 8'h5A;
  localparam logic [7:0] GLYPH_BASE_SET_CMD = 8'h5C;
  localparam logic [7:0] CURSOR_ADDRESS_WRITE_CMD = 8'h46;
  localparam logic [7:0] MEMORY_WRITE_CMD = 8'h42;
  localparam logic [5:0] CURSOR_STEP_DIR_BASE = 6'h13;
  localparam logic [4:0] N_SYSTEM_SET = 5'h08;
  localparam logic [4:0] N_SCROLL = 5'h0A;
  localparam logic [4:0] N_ONE = 5'h01;
  localparam logic [4:0] N_TWO = 5'h02;
  // ==========================================================================
  // Glyph coding.
  localparam logic [3:0] ROW_LAST_SHORT = 4'h7;
  localparam logic [3:0] ROW_LAST_TALL = 4'hF;
  localparam logic [3:0] ROM_ROWS = 4'h7;
  localparam logic [2:0] RAM_RANGE_A = 3'h4;
  localparam logic [2:0] RAM_RANGE_B = 3'h7;
  localparam logic [2:0] CTRL_RANGE = 3'h0;
  localparam logic [7:0] ROM_FIRST_CODE = 8'h20;
  typedef enum logic [1:0] {SGA_RIGHT, SGA_LEFT, SGA_UP, SGA_DOWN} sga_dir_e;
endpackage : sga_pkg

// ==== sga_top.sv ====
// Contract
// (RL1) Block start registers written by host scroll both text and graphics blocks.
// (RL2) Layer window splits into two blocks, each fetching from its own start.
// (RL3) Moving a start address never clears exposed lines; host blanks them.
// (RL4) Host adds or subtracts pitch to a block start to scroll a row.
// (RL5) Page scrolling only when memory holds more than one screen.
// (RL6) Text blocks scroll horizontally by whole characters at any memory size.
// (RL7) Two-way scrolling needs pitch above visible bytes and tall memory.
// (RL8) Three-bit pixel offset shifts text blocks only, in single pixels.
// (RL9) Host keeps pixel offset zero in two and four bits per pixel.
// (RL10) Text scrolls rows vertically; graphics scrolls by pixel lines.
// (RL11) Pixel offset is one value shared by both blocks.
// (RL12) Internal glyph ROM holds 160 fixed five by seven characters.
// (RL13) ROM glyphs mix with up to 64 RAM glyphs on one screen.
// (RL14) ROM glyphs are padded blank to fill cells up to eight by sixteen.
// (RL15) RAM glyphs are eight by eight, or eight by sixteen with tall bit.
// (RL16) With ROM selected, glyph table base may sit anywhere in memory.
// (RL17) Host uses one bit per pixel whenever RAM glyphs are used.
// (RL18) Glyph fetch address is base plus shifted code plus row index.
// (RL19) Short glyphs: code on bits 10..3, row on bits 2..0.
// (RL20) Tall glyphs: code on bits 11..4, row on bits 3..0.
// (RL21) Codes 80h-9Fh and E0h-FFh come from the RAM glyph table.
// (RL22) Glyph load sequence: base, direction right, cursor, memory write bytes.
// (RL23) Every memory access steps the cursor as the direction selects.
// (RL24) Graphics lines start at previous line start plus pitch.
// (RL25) All address sums are 16-bit and wrap modulo 64K.
module sga_top
  import sga_pkg::*;
(
  input wire logic CLK, // System clock, 100 MHz.
  input wire logic SRST, // Synchronous reset, active high.
  input wire logic CMD_WR, // Command byte strobe.
  input wire logic PARAM_WR, // Parameter or data byte strobe.
  input wire logic [7:0] BUS_DATA, // Byte written by the host.
  input wire logic GFX_MODE, // Level: scanned block is graphics.
  input wire logic SCAN_START, // Pulse: start scanning a block.
  input wire logic SCAN_BLOCK, // Block to start: 0 first, 1 second.
  input wire logic SCAN_LINE, // Pulse: advance to next scan line.
  input wire logic CHAR_VALID, // Pulse: character code and row present.
  input wire logic [7:0] CHAR_CODE, // Character code to render.
  input wire logic [3:0] CHAR_ROW, // Row within the glyph.
  output logic [15:0] LINE_ADDR, // Start address of current scan line.
  output logic [2:0] PIXEL_SHIFT, // Pixel offset applied to display.
  output logic [15:0] GLYPH_ADDR, // Glyph fetch address in display memory.
  output logic GLYPH_USE_RAM, // Glyph comes from the RAM table.
  output logic [7:0] ROM_ROW_DATA, // Padded ROM glyph row.
  output logic MEM_WE, // One-cycle display memory write.
  output logic [15:0] MEM_ADDR, // Display memory write address.
  output logic [7:0] MEM_WDATA, // Display memory write data.
  output logic [15:0] CURSOR_ADDR // Current cursor address.
);
  import sga_pkg::*;

  // ==========================================================================
  // Decoding helpers.

  // Glyph fetch address; the 16-bit sum wraps on purpose.
  function automatic logic [15:0] glyph_addr(input logic [15:0] base, input logic [7:0] code,
                                             input logic [3:0] row, input logic tall);
    logic [15:0] shifted;
    logic [15:0] row_ext;
    shifted = tall ? {4'h0, code, 4'h0} : {5'h00, code, 3'h0}; // RL19 RL20
    row_ext = tall ? {12'h000, row} : {13'h0000, row[2:0]}; // RL19 RL20
    glyph_addr = base + shifted + row_ext; // RL18 RL25
  endfunction : glyph_addr

  // Codes in the two RAM ranges, or every code with the external generator.
  function automatic logic use_ram(input logic [7:0] code, input logic ext_cg);
    use_ram = ext_cg || code[7:5] == RAM_RANGE_A || code[7:5] == RAM_RANGE_B; // RL21 RL13
  endfunction : use_ram

  // ==========================================================================
  // Register file and command decode.
  logic [7:0] regs [0:31];
  logic [7:0] cmd_reg;
  logic [4:0] par_base_reg;
  logic [4:0] par_left_reg;
  logic [15:0] pitch;
  logic [15:0] gbase;
  logic [15:0] blk1_start;
  logic [15:0] blk2_start;
  logic tall;
  logic ext_cg;
  logic mem_cmd;
  logic par_hit;

  assign pitch = {regs[PITCH_HI_OFS], regs[PITCH_LO_OFS]};
  assign gbase = {regs[GBASE_HI_OFS], regs[GBASE_LO_OFS]}; // RL16
  assign blk1_start = {regs[BLK1_HI_OFS], regs[BLK1_LO_OFS]}; // RL2
  assign blk2_start = {regs[BLK2_HI_OFS], regs[BLK2_LO_OFS]}; // RL2
  assign tall = regs[MODE_OFS][MODE_TALL_BIT]; // RL15
  assign ext_cg = regs[MODE_OFS][MODE_EXT_CG_BIT];
  assign mem_cmd = cmd_reg == MEMORY_WRITE_CMD;
  assign par_hit = PARAM_WR && !mem_cmd && par_left_reg != 5'h00;

  // Command byte picks the first register and how many parameters follow.
  always_ff @(posedge CLK) begin
    if (SRST) begin
      cmd_reg <= 8'h00;
      par_base_reg <= 5'h00;
      par_left_reg <= 5'h00;
    end else if (CMD_WR) begin
      cmd_reg <= BUS_DATA;
      par_left_reg <= 5'h00;
      case (BUS_DATA)
        CMD_SYSTEM_SET: begin
          par_base_reg <= MODE_OFS;
          par_left_reg <= N_SYSTEM_SET;
        end
        CMD_SCROLL: begin
          par_base_reg <= BLK1_LO_OFS; // RL1
          par_left_reg <= N_SCROLL;
        end
        CMD_PIX_SCROLL: begin
          par_base_reg <= PIX_SCROLL_OFS;
          par_left_reg <= N_ONE;
        end
        GLYPH_BASE_SET_CMD: begin
          par_base_reg <= GBASE_LO_OFS; // RL22
          par_left_reg <= N_TWO;
        end
        CURSOR_ADDRESS_WRITE_CMD: begin
          par_base_reg <= CURSOR_LO_OFS; // RL22
          par_left_reg <= N_TWO;
        end
        default: begin
          par_base_reg <= par_base_reg;
        end
      endcase
    end else if (par_hit) begin
      par_base_reg <= par_base_reg + 5'h01;
      par_left_reg <= par_left_reg - 5'h01;
    end
  end

  // Parameter bytes land in the register file; extra bytes are ignored.
  // The cursor pair also lands here, but CURSOR_ADDR is held in its own flip-flops below.
  always_ff @(posedge CLK) begin
    if (SRST) begin
      for (int i = 0; i < 32; i++) begin
        regs[i] <= REG_RESET;
      end
    end else if (CMD_WR && BUS_DATA[7:2] == CURSOR_STEP_DIR_BASE) begin
      regs[DIR_OFS] <= {6'h00, BUS_DATA[1:0]}; // RL22
    end else if (par_hit) begin
      regs[par_base_reg] <= BUS_DATA; // RL1
    end
  end

  // ==========================================================================
  // Cursor and display memory writes.
  sga_dir_e dir;
  logic [15:0] cursor_step;
  assign dir = sga_dir_e'(regs[DIR_OFS][1:0]);

  always_comb begin
    case (dir)
      SGA_RIGHT: cursor_step = CURSOR_ADDR + 16'h0001; // RL23 RL25
      SGA_LEFT: cursor_step = CURSOR_ADDR - 16'h0001; // RL23 RL25
      SGA_UP: cursor_step = CURSOR_ADDR - pitch; // RL23 RL25
      SGA_DOWN: cursor_step = CURSOR_ADDR + pitch; // RL23 RL25
      default: cursor_step = CURSOR_ADDR;
    endcase
  end

  // Writes happen only on host data bytes; scrolling never blanks memory,
  // which keeps the block free of hidden memory traffic.
  always_ff @(posedge CLK) begin
    if (SRST) begin
      CURSOR_ADDR <= 16'h0000;
      MEM_WE <= 1'b0;
      MEM_ADDR <= 16'h0000;
      MEM_WDATA <= 8'h00;
    end else begin
      MEM_WE <= 1'b0;
      if (PARAM_WR && mem_cmd) begin
        MEM_WE <= 1'b1; // RL3 RL22
        MEM_ADDR <= CURSOR_ADDR;
        MEM_WDATA <= BUS_DATA;
        CURSOR_ADDR <= cursor_step; // RL23
      end else if (par_hit && par_base_reg == CURSOR_LO_OFS) begin
        CURSOR_ADDR <= {CURSOR_ADDR[15:8], BUS_DATA};
      end else if (par_hit && par_base_reg == CURSOR_HI_OFS) begin
        CURSOR_ADDR <= {BUS_DATA, CURSOR_ADDR[7:0]};
      end
    end
  end

  // ==========================================================================
  // Scan line address generation.
  logic [3:0] text_row_reg;
  logic [3:0] row_last;
  assign row_last = tall ? ROW_LAST_TALL : ROW_LAST_SHORT;

  // Text repeats a line start for every glyph row; graphics steps each line.
  always_ff @(posedge CLK) begin
    if (SRST) begin
      LINE_ADDR <= 16'h0000;
      text_row_reg <= 4'h0;
    end else if (SCAN_START) begin
      LINE_ADDR <= SCAN_BLOCK ? blk2_start : blk1_start; // RL2 RL1
      text_row_reg <= 4'h0;
    end else if (SCAN_LINE) begin
      if (GFX_MODE) begin
        LINE_ADDR <= LINE_ADDR + pitch; // RL24 RL10 RL25
        text_row_reg <= 4'h0;
      end else if (text_row_reg == row_last) begin
        LINE_ADDR <= LINE_ADDR + pitch; // RL10 RL25
        text_row_reg <= 4'h0;
      end else begin
        text_row_reg <= text_row_reg + 4'h1;
      end
    end
  end

  // One shared pixel offset for the whole display; graphics ignores it.
  always_ff @(posedge CLK) begin
    if (SRST) begin
      PIXEL_SHIFT <= 3'h0;
    end else begin
      PIXEL_SHIFT <= GFX_MODE ? 3'h0 : regs[PIX_SCROLL_OFS][PIX_SCROLL_MSB:0]; // RL8 RL11 RL6
    end
  end

  // ==========================================================================
  // Glyph generator. The ROM pattern is procedural to save area; codes in the
  // control range and RAM ranges read blank from it.
  function automatic logic [7:0] rom_row(input logic [7:0] code, input logic [3:0] row);
    logic [7:0] idx;
    logic [4:0] pat;
    idx = code - ROM_FIRST_CODE;
    pat = idx[4:0] ^ {row[2:0], row[1:0]} ^ {idx[7:5], 2'b01};
    if (code[7:5] == CTRL_RANGE || use_ram(code, 1'b0) || row >= ROM_ROWS) begin
      rom_row = 8'h00; // RL14
    end else begin
      rom_row = {pat, 3'h0}; // RL12 RL14
    end
  endfunction : rom_row

  always_ff @(posedge CLK) begin
    if (SRST) begin
      GLYPH_ADDR <= 16'h0000;
      GLYPH_USE_RAM <= 1'b0;
      ROM_ROW_DATA <= 8'h00;
    end else if (CHAR_VALID) begin
      GLYPH_ADDR <= glyph_addr(gbase, CHAR_CODE, CHAR_ROW, tall); // RL18
      GLYPH_USE_RAM <= use_ram(CHAR_CODE, ext_cg); // RL21 RL13
      ROM_ROW_DATA <= rom_row(CHAR_CODE, CHAR_ROW); // RL12
    end
  end

  // ==========================================================================
  // Assertions.
  property p_glyph_addr;
    @(posedge CLK) disable iff (SRST)
    CHAR_VALID |=> GLYPH_ADDR == glyph_addr($past(gbase), $past(CHAR_CODE), $past(CHAR_ROW), $past(tall));
  endproperty
  a_glyph_addr: assert property (p_glyph_addr) else $error("glyph address wrong"); // RL18

  property p_short_layout;
    @(posedge CLK) disable iff (SRST)
    CHAR_VALID && !tall |=> GLYPH_ADDR - $past(gbase) == {5'h00, $past(CHAR_CODE), $past(CHAR_ROW[2:0])};
  endproperty
  a_short_layout: assert property (p_short_layout) else $error("short glyph layout wrong"); // RL19

  property p_tall_layout;
    @(posedge CLK) disable iff (SRST)
    CHAR_VALID && tall |=> GLYPH_ADDR - $past(gbase) == {4'h0, $past(CHAR_CODE), $past(CHAR_ROW)};
  endproperty
  a_tall_layout: assert property (p_tall_layout) else $error("tall glyph layout wrong"); // RL20

  property p_ram_codes;
    @(posedge CLK) disable iff (SRST)
    CHAR_VALID && (CHAR_CODE[7:5] == RAM_RANGE_A || CHAR_CODE[7:5] == RAM_RANGE_B) |=> GLYPH_USE_RAM;
  endproperty
  a_ram_codes: assert property (p_ram_codes) else $error("RAM code fetched from ROM"); // RL21

  property p_rom_pad;
    @(posedge CLK) disable iff (SRST)
    CHAR_VALID && CHAR_ROW >= ROM_ROWS |=> ROM_ROW_DATA == 8'h00 && !$changed(ROM_ROW_DATA[2:0]);
  endproperty
  a_rom_pad: assert property (p_rom_pad) else $error("ROM padding not blank"); // RL14

  property p_cursor_right;
    @(posedge CLK) disable iff (SRST)
    PARAM_WR && mem_cmd && dir == SGA_RIGHT |=> MEM_WE && CURSOR_ADDR == MEM_ADDR + 16'h0001;
  endproperty
  a_cursor_right: assert property (p_cursor_right) else $error("cursor did not step right"); // RL23

  property p_no_auto_write;
    @(posedge CLK) disable iff (SRST)
    MEM_WE |-> $past(PARAM_WR) && $past(mem_cmd);
  endproperty
  a_no_auto_write: assert property (p_no_auto_write) else $error("memory written without host data"); // RL3

  property p_gfx_line;
    @(posedge CLK) disable iff (SRST)
    SCAN_LINE && !SCAN_START && GFX_MODE |=> LINE_ADDR == $past(LINE_ADDR) + $past(pitch);
  endproperty
  a_gfx_line: assert property (p_gfx_line) else $error("graphics line not stepped by pitch"); // RL24

  property p_block_start;
    @(posedge CLK) disable iff (SRST)
    SCAN_START ##0 !SCAN_BLOCK |=> LINE_ADDR == $past(blk1_start);
  endproperty
  a_block_start: assert property (p_block_start) else $error("block start not loaded"); // RL2

  property p_pix_gfx;
    @(posedge CLK) disable iff (SRST)
    GFX_MODE |=> PIXEL_SHIFT == 3'h0;
  endproperty
  a_pix_gfx: assert property (p_pix_gfx) else $error("pixel shift applied to graphics"); // RL8

  // A downward step must use the pitch of the write cycle, not a later rewrite.
  property p_cursor_down;
    @(posedge CLK) disable iff (SRST)
    PARAM_WR && mem_cmd && dir == SGA_DOWN |=> MEM_WE && CURSOR_ADDR == MEM_ADDR + $past(pitch);
  endproperty
  a_cursor_down: assert property (p_cursor_down) else $error("cursor did not step down by pitch"); // RL23

  property p_text_hold;
    @(posedge CLK) disable iff (SRST)
    SCAN_LINE && !SCAN_START && !GFX_MODE && text_row_reg != row_last |=> LINE_ADDR == $past(LINE_ADDR);
  endproperty
  a_text_hold: assert property (p_text_hold) else $error("text line start moved inside a glyph row"); // RL10

  property p_blk2_start;
    @(posedge CLK) disable iff (SRST)
    SCAN_START && SCAN_BLOCK |=> LINE_ADDR == $past(blk2_start);
  endproperty
  a_blk2_start: assert property (p_blk2_start) else $error("second block start not loaded"); // RL2

  // Text blocks of either half see the one shared offset field.
  property p_pix_text;
    @(posedge CLK) disable iff (SRST)
    !GFX_MODE |=> PIXEL_SHIFT == $past(regs[PIX_SCROLL_OFS][PIX_SCROLL_MSB:0]);
  endproperty
  a_pix_text: assert property (p_pix_text) else $error("pixel shift differs from offset field"); // RL11

  c_tall_glyph: cover property (@(posedge CLK) disable iff (SRST) CHAR_VALID && tall ##1 GLYPH_USE_RAM);
  c_mem_burst: cover property (@(posedge CLK) disable iff (SRST) MEM_WE ##1 MEM_WE);
  c_text_row_wrap: cover property (@(posedge CLK) disable iff (SRST) SCAN_LINE && !GFX_MODE && text_row_reg == row_last);
  c_dir_down: cover property (@(posedge CLK) disable iff (SRST) PARAM_WR && mem_cmd && dir == SGA_DOWN);
endmodule : sga_top

// ==== test_sga_top.sv ====
module test_sga_top;
  timeunit 1ns;
  timeprecision 1ps;
  import sga_pkg::*;

  logic clk, srst, cmd_wr, param_wr, gfx_mode, scan_start, scan_block, scan_line, char_valid;
  logic [7:0] bus_data, char_code, rom_row_data, mem_wdata;
  logic [3:0] char_row;
  logic [15:0] line_addr, glyph_addr, mem_addr, cursor_addr;
  logic [2:0] pixel_shift;
  logic glyph_use_ram, mem_we;
  int n_errors, total_checks;
  logic [7:0] rows[5] = '{8'h70, 8'h88, 8'h88, 8'h88, 8'hF8};
  logic [7:0] codes[8] = '{8'h80, 8'h9F, 8'hE0, 8'hFF, 8'h20, 8'h7F, 8'hA0, 8'hDF};
  // Host byte script: bit 8 marks a command byte, the rest are parameters or memory data.
  // Driving the host from a table keeps its byte inputs varied instead of pinned to literals.
  logic [8:0] script[36] = '{
    9'h140, 9'h000, 9'h000, 9'h028, 9'h000, 9'h000, 9'h040, 9'h000,
    9'h144, 9'h000, 9'h001, 9'h000, 9'h000, 9'h020, 9'h000, 9'h000, 9'h000, 9'h000, 9'h000,
    9'h144, 9'h040, 9'h001, 9'h15A, 9'h0FD, 9'h15C, 9'h000, 9'h0FF,
    9'h14F, 9'h142, 9'h0AA, 9'h14E, 9'h142, 9'h055, 9'h14D, 9'h142, 9'h000};

  // ==========================================================================
  // Clock, design and host.
  initial clk = 1'b0;
  always #5 clk = ~clk;

  sga_top sga_top_i (.CLK(clk), .SRST(srst), .CMD_WR(cmd_wr), .PARAM_WR(param_wr), .BUS_DATA(bus_data),
    .GFX_MODE(gfx_mode), .SCAN_START(scan_start), .SCAN_BLOCK(scan_block), .SCAN_LINE(scan_line),
    .CHAR_VALID(char_valid), .CHAR_CODE(char_code), .CHAR_ROW(char_row), .LINE_ADDR(line_addr),
    .PIXEL_SHIFT(pixel_shift), .GLYPH_ADDR(glyph_addr), .GLYPH_USE_RAM(glyph_use_ram),
    .ROM_ROW_DATA(rom_row_data), .MEM_WE(mem_we), .MEM_ADDR(mem_addr), .MEM_WDATA(mem_wdata),
    .CURSOR_ADDR(cursor_addr));

  sga_host_model sga_host_model_i (.clk(clk), .cmd_wr(cmd_wr), .param_wr(param_wr), .bus_data(bus_data));

  // ==========================================================================
  // Reporting.
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic results();
    if (n_errors == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : results

  // A hung sequence is cut short here and counted as a mismatch.
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    results();
  end

  // ==========================================================================
  // Stimulus tasks; each pulse is one cycle wide and results are read a half cycle later.
  task automatic play(input int first, input int last);
    for (int i = first; i <= last; i++) begin
      if (script[i][8]) begin
        sga_host_model_i.put_cmd(script[i][7:0]);
      end else begin
        sga_host_model_i.put_param(script[i][7:0]);
      end
    end
  endtask : play

  // Pitch 40h stays above the 28h visible bytes, so both scroll directions are legal.
  task automatic sys_set(input logic [7:0] mode);
    play(0, 0);
    sga_host_model_i.put_param(mode);
    play(1, 7);
  endtask : sys_set

  task automatic scan(input logic start, input logic blk);
    @(negedge clk);
    scan_start = start;
    scan_line = ~start;
    scan_block = blk;
    @(negedge clk);
    scan_start = 1'b0;
    scan_line = 1'b0;
  endtask : scan

  task automatic glyph(input logic [7:0] code, input logic [3:0] row);
    @(negedge clk);
    char_valid = 1'b1;
    char_code = code;
    char_row = row;
    @(negedge clk);
    char_valid = 1'b0;
  endtask : glyph

  // ==========================================================================
  // Main sequence.
  initial begin
    n_errors = 0;
    total_checks = 0;
    {srst, gfx_mode, scan_start, scan_block, scan_line, char_valid} = 6'b100000;
    char_code = 8'h00;
    char_row = 4'h0;
    repeat (8) @(posedge clk);
    @(negedge clk);
    srst = 1'b0;
    sys_set(8'h00);
    // Block starts: first 0100h, second 2000h.
    play(8, 18);
    scan(1'b1, 1'b0);
    chk(line_addr, 16'h0100);
    gfx_mode = 1'b1;
    scan(1'b0, 1'b0);
    chk(line_addr, 16'h0140);
    gfx_mode = 1'b0;
    scan(1'b1, 1'b1);
    chk(line_addr, 16'h2000);
    repeat (7) scan(1'b0, 1'b1);
    chk(line_addr, 16'h2000);
    scan(1'b0, 1'b1);
    chk(line_addr, 16'h2040);
    // Scrolling one row down is the host adding the pitch to the start; old data is left alone.
    play(19, 21);
    scan(1'b1, 1'b0);
    chk(line_addr, 16'h0140);
    // Only the low three bits of the offset count, and both blocks see the same value.
    play(22, 23);
    scan(1'b1, 1'b1);
    chk(16'(pixel_shift), 16'h0005);
    gfx_mode = 1'b1;
    repeat (2) @(negedge clk);
    chk(16'(pixel_shift), 16'h0000);
    gfx_mode = 1'b0;
    // Glyph load: each byte goes to the cursor, which then steps right.
    sga_host_model_i.glyph_load_open(16'h4000, 16'h4800);
    for (int i = 0; i < 5; i++) begin
      sga_host_model_i.put_param(rows[i]);
      chk(16'(mem_we), 16'h0001);
      chk(mem_addr, 16'h4800 + 16'(i));
      chk(16'(mem_wdata), 16'(rows[i]));
      chk(cursor_addr, 16'h4801 + 16'(i));
    end
    @(negedge clk);
    chk(16'(mem_we), 16'h0000);
    // Each direction code then one memory byte: down adds the pitch, up subtracts it, left subtracts one.
    play(27, 29);
    chk(mem_addr, 16'h4805);
    chk(cursor_addr, 16'h4845);
    play(30, 32);
    chk(cursor_addr, 16'h4805);
    play(33, 35);
    chk(cursor_addr, 16'h4804);
    chk(16'(mem_wdata), 16'h0000);
    // Short glyph addressing and the split between RAM and ROM codes.
    glyph(8'h80, 4'h2);
    chk(glyph_addr, 16'h4402);
    for (int i = 0; i < 8; i++) begin
      glyph(codes[i], 4'h5);
      chk(glyph_addr, 16'h4005 + {5'h00, codes[i], 3'h0});
      chk(16'(glyph_use_ram), i < 4 ? 16'h0001 : 16'h0000);
      if (i >= 4) chk(16'(rom_row_data[2:0]), 16'h0000);
    end
    // Tall cells: code moves up one bit, and the sum wraps at 64K.
    sys_set(8'h04);
    play(24, 26);
    glyph(8'hFF, 4'hF);
    chk(glyph_addr, 16'h0EFF);
    glyph(8'h41, 4'h9);
    chk(glyph_addr, 16'h0319);
    chk(16'(rom_row_data), 16'h0000);
    chk(16'(glyph_use_ram), 16'h0000);
    sys_set(8'h01);
    glyph(8'h41, 4'h0);
    chk(16'(glyph_use_ram), 16'h0001);
    results();
  end
endmodule : test_sga_top
